// file: src/watchdog_timer_block.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_block
	import wdog_pkg::*;
#(
	parameter int TO_BITS0 = TO_BITS_S0,
	parameter int TO_BITS1 = TO_BITS_S1,
	parameter int TO_BITS2 = TO_BITS_S2,
	parameter int TO_BITS3 = TO_BITS_S3
) (
	input  wire logic          clk_sys,
	input  wire logic          rstn,
	input  wire logic [AW-1:0] reg_addr,
	input  wire logic [DW-1:0] reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output var  logic [DW-1:0] reg_rdata,
	input  wire logic          ext_reset_n,
	input  wire logic          power_fail_n,
	output var  logic          wdog_sys_reset,
	output var  logic          wdog_irq_req,
	output var  logic          irq
);

	typedef struct packed {
		logic [1:0]        ext_sync;
		logic [1:0]        pf_sync;
		wd_state_t         state;
		logic [POST_W-1:0] post_cnt;
		logic [HOLD_W-1:0] hold_cnt;
		logic              irqf;
		logic              cause;
		logic              rst_en;
		logic              restart;
		logic [DW-1:0]     clk_ctrl;
		logic              ie_wdog;
		logic              ie_global;
		logic              ta_armed;
		logic [TA_W-1:0]   ta_cnt;
		logic [NUM_EV-1:0] irq_stat;
		logic [NUM_EV-1:0] irq_mask;
		logic [DW-1:0]     rdata;
		logic              irq;
		logic              irq_req;
		logic              sys_reset;
	} wd_st_t;

	wd_st_t     st_r;
	wd_st_t     st_nxt;
	logic       ext_rst;
	logic       pf_rst;
	logic       ta_open;
	wdog_cnt_if cnt ();

	function automatic logic reg_hit(input logic strobe, input logic [AW-1:0] addr,
		input logic [AW-1:0] ofs);
		reg_hit = strobe && (addr == ofs);
	endfunction : reg_hit

	wdog_divider #(
		.TO_BITS0 (TO_BITS0),
		.TO_BITS1 (TO_BITS1),
		.TO_BITS2 (TO_BITS2),
		.TO_BITS3 (TO_BITS3)
	) u_divider (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.cnt     (cnt.div)
	);

	// pins are asynchronous: only the second stage is looked at
	assign ext_rst     = !st_r.ext_sync[1];
	assign pf_rst      = !st_r.pf_sync[1];
	assign ta_open     = st_r.ta_cnt != '0;
	assign cnt.restart = st_r.restart;
	assign cnt.sel     = st_r.clk_ctrl[SEL_LSB +: SEL_W];

	always_comb begin
		logic [DW-1:0] ctl_view;
		ctl_view = '0;
		st_nxt = st_r;
		st_nxt.ext_sync = {st_r.ext_sync[0], ext_reset_n};
		st_nxt.pf_sync  = {st_r.pf_sync[0], power_fail_n};
		st_nxt.restart  = 1'h0;

		if (ta_open) begin
			st_nxt.ta_cnt = st_r.ta_cnt - TA_W'(1);
		end
		if (reg_hit(reg_wr, reg_addr, OFS_TA_KEY)) begin
			if (reg_wdata == TA_KEY1) begin
				st_nxt.ta_armed = 1'h1;
			end else if (st_r.ta_armed && reg_wdata == TA_KEY2) begin
				st_nxt.ta_armed = 1'h0;
				st_nxt.ta_cnt   = TA_LOAD;
			end else begin
				st_nxt.ta_armed = 1'h0;
			end
		end else if (reg_wr) begin
			st_nxt.ta_armed = 1'h0;
		end

		if (reg_hit(reg_wr, reg_addr, OFS_WDOG_CTRL)) begin
			if (!reg_wdata[BIT_CAUSE]) begin
				st_nxt.cause = 1'h0;
			end
			if (ta_open) begin
				st_nxt.rst_en  = reg_wdata[BIT_RST_EN];
				st_nxt.irqf    = reg_wdata[BIT_IRQF];
				st_nxt.restart = reg_wdata[BIT_RESTART];
			end
		end
		if (reg_hit(reg_wr, reg_addr, OFS_CLK_CTRL)) begin
			st_nxt.clk_ctrl = reg_wdata;
		end
		if (reg_hit(reg_wr, reg_addr, OFS_IRQ_STAT)) begin
			st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata[NUM_EV-1:0];
		end
		if (reg_hit(reg_wr, reg_addr, OFS_IRQ_MASK)) begin
			st_nxt.irq_mask = reg_wdata[NUM_EV-1:0];
		end
		if (reg_hit(reg_wr, reg_addr, OFS_IRQ_EN)) begin
			st_nxt.ie_wdog   = reg_wdata[BIT_EXT_IE];
			st_nxt.ie_global = reg_wdata[BIT_GLOBAL_IE];
		end

		case (st_r.state)
			WD_RUN: begin
				if (cnt.timeout) begin
					st_nxt.state    = WD_PENDING;
					st_nxt.post_cnt = '0;
				end
			end
			WD_PENDING: begin
				if (st_r.restart) begin
					st_nxt.state = WD_RUN;
				end else if (st_r.post_cnt == POST_LAST) begin
					if (st_r.rst_en) begin
						st_nxt.state    = WD_RESET;
						st_nxt.hold_cnt = '0;
						st_nxt.cause    = 1'h1;
						st_nxt.irq_stat[EV_WDRST] = 1'h1;
					end else begin
						st_nxt.state = WD_RUN;
					end
				end else begin
					st_nxt.post_cnt = st_r.post_cnt + POST_W'(1);
				end
			end
			WD_RESET: begin
				if (st_r.hold_cnt == HOLD_LAST) begin
					st_nxt.state = WD_RUN;
				end else begin
					st_nxt.hold_cnt = st_r.hold_cnt + HOLD_W'(1);
				end
			end
			default: begin
				st_nxt.state = WD_RUN;
			end
		endcase

		// flag on every time-out not met by a reset in the same cycle; placed after the writes so the set wins
		if (cnt.timeout) begin
			st_nxt.irqf = 1'h1;
			st_nxt.irq_stat[EV_TIMEOUT] = 1'h1;
		end

		// watchdog reset keeps enable, restarts count
		if (st_nxt.state == WD_RESET || ext_rst || pf_rst) begin
			st_nxt.irqf      = 1'h0;
			st_nxt.restart   = 1'h1;
			st_nxt.clk_ctrl  = CLK_CTRL_RST;
			st_nxt.ie_wdog   = 1'h0;
			st_nxt.ie_global = 1'h0;
			st_nxt.ta_armed  = 1'h0;
			st_nxt.ta_cnt    = '0;
		end
		if (ext_rst || pf_rst) begin
			st_nxt.state    = WD_RUN;
			st_nxt.irq_stat = '0;
			st_nxt.irq_mask = '0;
		end
		if (pf_rst) begin
			st_nxt.rst_en = 1'h0;
			st_nxt.cause  = 1'h0;
		end

		// outputs registered in step with the state they describe
		st_nxt.sys_reset = st_nxt.state == WD_RESET;
		// irq path apart from reset path
		st_nxt.irq_req = st_nxt.irqf && st_nxt.ie_wdog && st_nxt.ie_global;
		st_nxt.irq     = |(st_nxt.irq_stat & st_nxt.irq_mask);

		ctl_view[BIT_IRQF]    = st_r.irqf;
		ctl_view[BIT_CAUSE]   = st_r.cause;
		ctl_view[BIT_RST_EN]  = st_r.rst_en;
		ctl_view[BIT_RESTART] = st_r.restart;
		st_nxt.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				OFS_WDOG_CTRL: st_nxt.rdata = ctl_view;
				OFS_CLK_CTRL:  st_nxt.rdata = st_r.clk_ctrl;
				OFS_TA_KEY:    st_nxt.rdata = DW'(ta_open);
				OFS_IRQ_STAT:  st_nxt.rdata = DW'(st_r.irq_stat);
				OFS_IRQ_MASK:  st_nxt.rdata = DW'(st_r.irq_mask);
				OFS_IRQ_EN: begin
					st_nxt.rdata[BIT_EXT_IE]    = st_r.ie_wdog;
					st_nxt.rdata[BIT_GLOBAL_IE] = st_r.ie_global;
				end
				default:       st_nxt.rdata = '0;
			endcase
		end
	end

	// power-on reset leaves the watchdog disabled; sync stages idle high
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_r          <= '0;
			st_r.ext_sync <= '1;
			st_r.pf_sync  <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata      = st_r.rdata;
	assign wdog_sys_reset = st_r.sys_reset;
	assign wdog_irq_req   = st_r.irq_req;
	assign irq            = st_r.irq;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	logic ctl_wr;
	logic quiet;
	assign ctl_wr = reg_hit(reg_wr, reg_addr, OFS_WDOG_CTRL);
	assign quiet  = !ext_rst && !pf_rst;

	sequence s_grace_end;
		st_r.state == WD_PENDING && st_r.post_cnt == POST_LAST && !st_r.restart;
	endsequence

	sequence s_wd_reset_start;
		$rose(wdog_sys_reset) && quiet;
	endsequence

	a_timeout_flag: assert property (cnt.timeout && quiet && st_nxt.state != WD_RESET |=> st_r.irqf)
		else $error("time-out did not set flag");
	a_irq_gate: assert property (wdog_irq_req == (st_r.irqf && st_r.ie_wdog && st_r.ie_global))
		else $error("irq request not gated by enables");
	a_grace_reset: assert property (s_grace_end ##0 (st_r.rst_en && quiet) |=> wdog_sys_reset)
		else $error("no reset after grace span");
	a_reset_hold: assert property (s_wd_reset_start |-> wdog_sys_reset[*8] ##1 !wdog_sys_reset)
		else $error("watchdog reset width wrong");
	a_cause_set: assert property ($rose(wdog_sys_reset) |-> st_r.cause)
		else $error("cause flag not set by reset");
	a_keep_enable: assert property (s_wd_reset_start |-> st_r.rst_en[*4])
		else $error("watchdog reset dropped enable");
	a_pf_disable: assert property (pf_rst |=> !st_r.rst_en && !st_r.cause)
		else $error("power-fail left watchdog armed");
	a_flag_cleared: assert property (!quiet |=> !st_r.irqf)
		else $error("reset did not clear flag");
	a_sel_default: assert property (!quiet |=> cnt.sel == SEL_DEFAULT)
		else $error("select not back to default");
	a_cause_steady: assert property (!st_r.rst_en && !reg_wr && !pf_rst |=> $stable(st_r.cause))
		else $error("cause flag moved while disabled");
	a_no_rst_dis: assert property (st_r.state == WD_PENDING && !st_r.rst_en |=> !wdog_sys_reset)
		else $error("reset issued while disabled");
	a_ta_guard: assert property (ctl_wr && !ta_open && quiet && !cnt.timeout
		&& st_nxt.state != WD_RESET
		|=> $stable(st_r.rst_en) && !st_r.restart && $stable(st_r.irqf))
		else $error("protected write outside window");

endmodule : watchdog_timer_block
`default_nettype wire

// file: inc/wdog_pkg.sv
package wdog_pkg;

	// register bus geometry
	localparam int AW   = 8;
	localparam int DW   = 8;

	// register offsets
	localparam logic [AW-1:0] OFS_WDOG_CTRL = 8'h00;
	localparam logic [AW-1:0] OFS_CLK_CTRL  = 8'h01;
	localparam logic [AW-1:0] OFS_TA_KEY    = 8'h02;
	localparam logic [AW-1:0] OFS_IRQ_STAT  = 8'h03;
	localparam logic [AW-1:0] OFS_IRQ_MASK  = 8'h04;
	localparam logic [AW-1:0] OFS_IRQ_EN    = 8'h05;

	// watchdog_control fields
	localparam int BIT_RESTART = 0;
	localparam int BIT_RST_EN  = 1;
	localparam int BIT_CAUSE   = 2;
	localparam int BIT_IRQF    = 3;

	// clock_control: timeout_select_hi/lo sit at bits 7:6
	localparam int             SEL_LSB      = 6;
	localparam int             SEL_W        = 2;
	localparam logic [DW-1:0]  CLK_CTRL_RST = 8'h00;
	localparam logic [SEL_W-1:0] SEL_DEFAULT = 2'h0;

	// irq_enable fields
	localparam int BIT_EXT_IE    = 4;
	localparam int BIT_GLOBAL_IE = 7;

	// sticky event bits of irq_status / irq_mask
	localparam int EV_TIMEOUT = 0;
	localparam int EV_WDRST   = 1;
	localparam int NUM_EV     = 2;

	// timed-access key sequence and window length in clocks
	localparam logic [DW-1:0] TA_KEY1       = 8'hAA;
	localparam logic [DW-1:0] TA_KEY2       = 8'h55;
	localparam int            TA_WINDOW_CLK = 4;
	localparam int            TA_W          = 3;
	localparam logic [TA_W-1:0] TA_LOAD     = TA_W'(TA_WINDOW_CLK);

	// divider: log2 of the interval for each select code
	localparam int CNT_W      = 26;
	localparam int TO_BITS_S0 = 17;
	localparam int TO_BITS_S1 = 20;
	localparam int TO_BITS_S2 = 23;
	localparam int TO_BITS_S3 = 26;

	// grace span after a time-out and watchdog reset pulse length
	localparam int RST_DELAY_CLK   = 512;
	localparam int MACHINE_CYC_CLK = 4;
	localparam int RST_HOLD_MC     = 2;
	localparam int RST_HOLD_CLK    = RST_HOLD_MC * MACHINE_CYC_CLK;
	localparam int POST_W          = $clog2(RST_DELAY_CLK);
	localparam int HOLD_W          = $clog2(RST_HOLD_CLK);
	localparam logic [POST_W-1:0] POST_LAST = POST_W'(RST_DELAY_CLK - 1);
	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RST_HOLD_CLK - 1);

	typedef enum logic [1:0] {
		WD_RUN,
		WD_PENDING,
		WD_RESET
	} wd_state_t;

endpackage : wdog_pkg

// file: inc/wdog_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wdog_cnt_if;
	logic       restart;
	logic [1:0] sel;
	logic       timeout;

	modport ctl (output restart, output sel, input timeout);
	modport div (input restart, input sel, output timeout);
endinterface : wdog_cnt_if
`default_nettype wire

// file: src/wdog_divider.sv
`timescale 1ns/1ps
`default_nettype none
module wdog_divider
	import wdog_pkg::*;
#(
	parameter int TO_BITS0 = TO_BITS_S0,
	parameter int TO_BITS1 = TO_BITS_S1,
	parameter int TO_BITS2 = TO_BITS_S2,
	parameter int TO_BITS3 = TO_BITS_S3
) (
	input wire logic clk_sys,
	input wire logic rstn,
	wdog_cnt_if.div  cnt
);

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic             timeout;
	} div_st_t;

	div_st_t st_r;
	div_st_t st_nxt;

	function automatic logic [CNT_W-1:0] sel_mask(input logic [1:0] sel);
		int bits;
		case (sel)
			2'h0:    bits = TO_BITS0;
			2'h1:    bits = TO_BITS1;
			2'h2:    bits = TO_BITS2;
			default: bits = TO_BITS3;
		endcase
		sel_mask = (CNT_W'(1) << bits) - CNT_W'(1);
	endfunction : sel_mask

	always_comb begin
		st_nxt = st_r;
		if (cnt.restart) begin
			st_nxt.count   = '0;
			st_nxt.timeout = 1'h0;
		end else begin
			st_nxt.count   = st_r.count + CNT_W'(1);
			st_nxt.timeout = (st_r.count & sel_mask(cnt.sel)) == sel_mask(cnt.sel);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cnt.timeout = st_r.timeout;

	property p_restart_zero;
		@(posedge clk_sys) disable iff (!rstn)
		cnt.restart |=> (st_r.count == '0) && !cnt.timeout;
	endproperty
	a_restart_zero: assert property (p_restart_zero) else $error("restart did not clear divider");

	property p_tap_fires;
		@(posedge clk_sys) disable iff (!rstn)
		(!cnt.restart && (st_r.count & sel_mask(cnt.sel)) == sel_mask(cnt.sel)) |=> cnt.timeout;
	endproperty
	a_tap_fires: assert property (p_tap_fires) else $error("time-out missed at tap");

	property p_single_pulse;
		@(posedge clk_sys) disable iff (!rstn)
		cnt.timeout |=> !cnt.timeout;
	endproperty
	a_single_pulse: assert property (p_single_pulse) else $error("time-out pulse too long");

endmodule : wdog_divider
`default_nettype wire

// file: test/watchdog_timer_block_tb.sv
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_block_tb
	import wdog_pkg::*;
;
	localparam int T0 = 6;
	localparam int T1 = 7;
	localparam int T2 = 8;
	localparam int T3 = 9;

	logic          clk_sys;
	logic          rstn;
	logic [AW-1:0] reg_addr;
	logic [DW-1:0] reg_wdata;
	logic          reg_wr;
	logic          reg_rd;
	logic [DW-1:0] reg_rdata;
	logic          ext_reset_n;
	logic          power_fail_n;
	logic          wdog_sys_reset;
	logic          wdog_irq_req;
	logic          irq;
	int            errors;
	int            compares;
	int            rst_cnt  = 0;
	logic          rst_prev = 1'h0;
	int            tob[4] = '{T0, T1, T2, T3};

	watchdog_timer_block #(.TO_BITS0(T0), .TO_BITS1(T1), .TO_BITS2(T2), .TO_BITS3(T3)) dut (
		.clk_sys        (clk_sys),
		.rstn           (rstn),
		.reg_addr       (reg_addr),
		.reg_wdata      (reg_wdata),
		.reg_wr         (reg_wr),
		.reg_rd         (reg_rd),
		.reg_rdata      (reg_rdata),
		.ext_reset_n    (ext_reset_n),
		.power_fail_n   (power_fail_n),
		.wdog_sys_reset (wdog_sys_reset),
		.wdog_irq_req   (wdog_irq_req),
		.irq            (irq)
	);

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// count watchdog reset pulses so quiet spans can be proven
	always @(posedge clk_sys) begin
		if (wdog_sys_reset === 1'b1 && !rst_prev) begin
			rst_cnt <= rst_cnt + 1;
		end
		rst_prev <= (wdog_sys_reset === 1'b1);
	end

	task automatic results();
		if (errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	// every task starts just off an edge, so no strobe is assigned twice per step
	task automatic cyc(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_rd    <= 1'b0;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		#1;
	endtask : wr

	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
		reg_addr <= a;
		reg_wr   <= 1'b0;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		#1;
		v = reg_rdata;
	endtask : rd

	task automatic rd_chk(input string name, input logic [AW-1:0] a, input logic [DW-1:0] e);
		logic [DW-1:0] v;
		rd(a, v);
		check(name, v, e);
	endtask : rd_chk

	task automatic ta_key();
		wr(OFS_TA_KEY, TA_KEY1);
		wr(OFS_TA_KEY, TA_KEY2);
	endtask : ta_key

	// which: 0 waits for the interrupt request, 1 for the system reset
	task automatic wait_for(input int which, input int lim, output int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		n = 0;
		while (((which == 0) ? wdog_irq_req : wdog_sys_reset) !== 1'b1) begin
			if (n >= lim) begin
				errors++;
				results();
			end
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask : wait_for

	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		results();
	end

	initial begin
		int n;
		int lo;
		int k;
		rstn         = 1'b0;
		reg_addr     = '0;
		reg_wdata    = '0;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		ext_reset_n  = 1'b1;
		power_fail_n = 1'b1;
		errors       = 0;
		compares     = 0;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		cyc(1);

		rd_chk("wdog_ctrl_rst", OFS_WDOG_CTRL, 8'h00);
		rd_chk("clk_ctrl_rst", OFS_CLK_CTRL, CLK_CTRL_RST);
		rd_chk("irq_en_rst", OFS_IRQ_EN, 8'h00);
		rd_chk("unmapped", 8'h3C, 8'h00);
		wr(OFS_CLK_CTRL, 8'hA5);
		rd_chk("clk_ctrl_rw", OFS_CLK_CTRL, 8'hA5);
		// protected bits ignore writes made without the key
		wr(OFS_WDOG_CTRL, 8'h0B);
		rd_chk("no_key_wr", OFS_WDOG_CTRL, 8'h00);
		ta_key();
		rd_chk("window_open", OFS_TA_KEY, 8'h01);
		cyc(4);
		wr(OFS_WDOG_CTRL, 8'h02);
		rd_chk("window_shut", OFS_WDOG_CTRL, 8'h00);

		// every select code, polled through the flag with reset disabled
		wr(OFS_IRQ_EN, 8'h90);
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CLK_CTRL, DW'(s << SEL_LSB));
			ta_key();
			wr(OFS_WDOG_CTRL, 8'h01);
			cyc(2);
			wait_for(0, 5000, n);
			lo = 1 << tob[s];
			check("timeout_gap", (n >= lo - 3 && n <= lo + 3), 1);
		end
		rd_chk("flag_set", OFS_WDOG_CTRL, 8'h08);
		wr(OFS_IRQ_EN, 8'h10);
		cyc(2);
		check("req_no_global", wdog_irq_req, 1'b0);
		wr(OFS_IRQ_EN, 8'h80);
		cyc(2);
		check("req_no_local", wdog_irq_req, 1'b0);
		wr(OFS_IRQ_EN, 8'h90);
		cyc(2);
		check("req_both", wdog_irq_req, 1'b1);
		ta_key();
		wr(OFS_WDOG_CTRL, 8'h00);
		cyc(1);
		rd_chk("flag_sw_clr", OFS_WDOG_CTRL, 8'h00);

		// unrestarted time-out with reset enabled
		wr(OFS_CLK_CTRL, 8'h40);
		wr(OFS_IRQ_MASK, 8'h02);
		ta_key();
		wr(OFS_WDOG_CTRL, 8'h03);
		cyc(2);
		wait_for(0, 5000, n);
		wait_for(1, 600, n);
		check("reset_delay", n, RST_DELAY_CLK);
		n = 0;
		while (wdog_sys_reset === 1'b1 && n < 40) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		check("reset_hold", n, RST_HOLD_CLK);
		cyc(1);
		rd_chk("after_wd_rst", OFS_WDOG_CTRL, 8'h06);
		rd_chk("sel_default", OFS_CLK_CTRL, 8'h00);
		rd_chk("irq_status", OFS_IRQ_STAT, 8'h03);
		check("irq_line", irq, 1'b1);
		wr(OFS_IRQ_STAT, 8'h03);
		cyc(2);
		check("irq_w1c", irq, 1'b0);
		// let a fresh time-out set the flag, so the external reset has something to clear
		cyc(64);
		rd_chk("flag_rearmed", OFS_WDOG_CTRL, 8'h0E);

		ext_reset_n <= 1'b0;
		cyc(4);
		ext_reset_n <= 1'b1;
		cyc(4);
		rd_chk("ext_rst_keep", OFS_WDOG_CTRL, 8'h06);
		power_fail_n <= 1'b0;
		cyc(4);
		power_fail_n <= 1'b1;
		cyc(4);
		rd_chk("pfail_clear", OFS_WDOG_CTRL, 8'h00);

		// restart inside the grace span cancels the pending reset
		wr(OFS_IRQ_EN, 8'h90);
		ta_key();
		wr(OFS_WDOG_CTRL, 8'h03);
		cyc(2);
		rd_chk("restart_selfclr", OFS_WDOG_CTRL, 8'h02);
		wait_for(0, 500, n);
		cyc(100);
		ta_key();
		wr(OFS_WDOG_CTRL, 8'h03);
		k = rst_cnt;
		cyc(450);
		check("restart_cancel", rst_cnt, k);

		// reset enable off: flag keeps coming, no reset
		ta_key();
		wr(OFS_WDOG_CTRL, 8'h01);
		k = rst_cnt;
		cyc(700);
		check("no_reset_off", rst_cnt, k);
		rd_chk("flag_only", OFS_WDOG_CTRL, 8'h08);
		cyc(1);
		results();
	end
endmodule : watchdog_timer_block_tb
`default_nettype wire
